/* File: clkgen_pkg.sv */
/*
 * Constants for the clock generator control block: register addresses, field
 * positions, reset values, reference choices and timing counts.
 * Assumes a 100 MHz core clock and an 8-bit register port with 16-bit addresses.
 */
package clkgen_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_POWER_STATE = 16'ha031;
    localparam logic [15:0] ADDR_PLL_CFG = 16'ha034;
    localparam logic [15:0] ADDR_PLL_STATUS = 16'ha035;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int POWER_ON_BIT = 4;
    localparam int OUT12_EN_BIT = 6;
    localparam int OUT48_EN_BIT = 7;
    localparam int LOCK_BIT = 0;
    localparam logic [7:0] PLL_CFG_RESET = 8'hc0;
    localparam logic [7:0] POWER_STATE_RESET = 8'h10;

    // ------------------------------------------------------------------
    // Reference choices decoded from the select field
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        REF_NONE,
        REF_26M,
        REF_32K,
        REF_12M,
        REF_13M,
        REF_19M2
    } pll_ref_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CORE_CLK_KHZ = 100000;
    localparam int POWER_OFF_DELAY_NS = 200;
    localparam int POWER_OFF_DELAY_CYC =
        (POWER_OFF_DELAY_NS * CORE_CLK_KHZ / 1000000 < 1) ? 1 :
        POWER_OFF_DELAY_NS * CORE_CLK_KHZ / 1000000;
    localparam int LOCK_TIME_US = 20;
    localparam int LOCK_CYC = LOCK_TIME_US * CORE_CLK_KHZ / 1000;
    localparam int MASTER_DIV = 6;
    localparam int LOW_DIV_8K = 4;
    localparam int LOW_DIV_1K = 32;

endpackage

/* File: clkgen_divider.sv */
/*
 * Integer clock divider driven by rising edges of a slow input level.
 * Assumes the source level has already been synchronised into the core domain.
 */
module clkgen_divider #(
    parameter int DIV = 4
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Source edges.
    input wire logic edge_i,
    // Divided square wave.
    output logic div_o
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic div_nxt;

    initial begin
        if (DIV < 2 || DIV % 2 != 0) begin
            $error("Divider ratio must be even and at least two.");
        end
    end

    // ------------------------------------------------------------------
    // Half-period counter
    // ------------------------------------------------------------------
    // Toggle every DIV/2 source edges so the output keeps a 50 percent duty.
    always_comb begin
        cnt_nxt = cnt_r;
        div_nxt = div_o;
        if (edge_i) begin
            if (cnt_r == CW'(DIV / 2 - 1)) begin
                cnt_nxt = '0;
                div_nxt = ~div_o;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
            div_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            div_o <= div_nxt;
        end
    end

endmodule

/* File: clkgen_ctrl.sv */
/*
 * Clock generator control: PLL select and output enables, generator power
 * state with delayed power-off, and the fixed-rate internal clocks.
 * Assumes a 100 MHz core clock, a byte-wide register port with one-cycle
 * strobes, and an asynchronous 32.768 kHz oscillator level on a pin.
 */
module clkgen_ctrl
    import clkgen_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYC
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Register port.
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // System events and source clocks.
    input wire logic cpu_irq_pending_i,
    input wire logic crystal_input_i,
    // Generator and PLL control.
    output logic generator_power_o,
    output logic pll_power_o,
    output logic [2:0] pll_ref_o,
    output logic main_pll_locked_o,
    output logic out12_en_o,
    output logic out48_en_o,
    // Internal clock enables and clocks.
    output logic master_logic_clock_o,
    output logic audio_pll_clock_en_o,
    output logic low_speed_clock_o,
    output logic eight_khz_tick_o,
    output logic one_khz_tick_o
);
    import clkgen_pkg::*;

    initial begin
        if (LOCK_CYCLES < 1) begin
            $error("Lock time must be at least one cycle.");
        end
    end

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic pll_ref_t decode_ref(input logic [2:0] sel);
        case (sel)
            3'h1, 3'h3: decode_ref = REF_26M;
            3'h2: decode_ref = REF_32K;
            3'h5: decode_ref = REF_12M;
            3'h6: decode_ref = REF_13M;
            3'h7: decode_ref = REF_19M2;
            default: decode_ref = REF_NONE;
        endcase
    endfunction

    typedef enum logic [1:0] {
        PWR_ON,
        PWR_DRAIN,
        PWR_OFF
    } pwr_state_t;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [7:0] pll_cfg_r;
    logic [7:0] pll_cfg_nxt;
    logic power_bit_r;
    logic power_bit_nxt;
    pwr_state_t pwr_r;
    pwr_state_t pwr_nxt;
    logic [7:0] drain_r;
    logic [7:0] drain_nxt;
    logic [31:0] lock_cnt_r;
    logic [31:0] lock_cnt_nxt;
    logic locked_r;
    logic locked_nxt;
    logic [7:0] rdata_nxt;
    logic xtal_s1_r;
    logic xtal_s2_r;
    logic xtal_d_r;
    logic xtal_edge;
    logic [2:0] mdiv_r;
    logic [2:0] mdiv_nxt;
    logic mclk_nxt;
    logic div8k;
    logic div1k;
    logic div8k_d_r;
    logic div1k_d_r;
    pll_ref_t ref_sel;

    // Synchronise the crystal level; only the second and third stages are examined.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            xtal_s1_r <= 1'b0;
            xtal_s2_r <= 1'b0;
            xtal_d_r <= 1'b0;
        end else begin
            xtal_s1_r <= crystal_input_i;
            xtal_s2_r <= xtal_s1_r;
            xtal_d_r <= xtal_s2_r;
        end
    end

    assign xtal_edge = xtal_s2_r & ~xtal_d_r;
    assign ref_sel = decode_ref(pll_cfg_r[2:0]);

    // ------------------------------------------------------------------
    // Register writes and power state
    // ------------------------------------------------------------------
    // The interrupt set wins over a simultaneous write-one clear, so a
    // wake request can never be lost in the clearing cycle.
    always_comb begin
        pll_cfg_nxt = pll_cfg_r;
        power_bit_nxt = power_bit_r;
        if (reg_wr_i && reg_addr_i == ADDR_PLL_CFG) begin
            pll_cfg_nxt = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == ADDR_POWER_STATE && reg_wdata_i[POWER_ON_BIT]) begin
            power_bit_nxt = 1'b0;
        end
        if (cpu_irq_pending_i) begin
            power_bit_nxt = 1'b1;
        end
    end

    // Power is dropped only after the drain delay so the access finishes.
    always_comb begin
        pwr_nxt = pwr_r;
        drain_nxt = drain_r;
        case (pwr_r)
            PWR_ON: begin
                if (!power_bit_r) begin
                    pwr_nxt = PWR_DRAIN;
                    drain_nxt = 8'(POWER_OFF_DELAY_CYC - 1);
                end
            end
            PWR_DRAIN: begin
                if (power_bit_r) begin
                    pwr_nxt = PWR_ON;
                end else if (drain_r == 8'h00) begin
                    pwr_nxt = PWR_OFF;
                end else begin
                    drain_nxt = drain_r - 8'h01;
                end
            end
            PWR_OFF: begin
                if (power_bit_r) begin
                    pwr_nxt = PWR_ON;
                end
            end
            default: pwr_nxt = PWR_ON;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            pll_cfg_r <= PLL_CFG_RESET;
            power_bit_r <= POWER_STATE_RESET[POWER_ON_BIT];
            pwr_r <= PWR_ON;
            drain_r <= 8'h00;
        end else begin
            pll_cfg_r <= pll_cfg_nxt;
            power_bit_r <= power_bit_nxt;
            pwr_r <= pwr_nxt;
            drain_r <= drain_nxt;
        end
    end

    // ------------------------------------------------------------------
    // PLL lock model
    // ------------------------------------------------------------------
    // Lock is declared a fixed time after the PLL is powered with a stable
    // reference; any reference change or power loss restarts the count.
    always_comb begin
        lock_cnt_nxt = lock_cnt_r;
        locked_nxt = locked_r;
        if (ref_sel == REF_NONE || pwr_r == PWR_OFF ||
            (reg_wr_i && reg_addr_i == ADDR_PLL_CFG &&
             reg_wdata_i[2:0] != pll_cfg_r[2:0])) begin
            lock_cnt_nxt = '0;
            locked_nxt = 1'b0;
        end else if (lock_cnt_r == 32'(LOCK_CYCLES - 1)) begin
            locked_nxt = 1'b1;
        end else begin
            lock_cnt_nxt = lock_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            lock_cnt_r <= '0;
            locked_r <= 1'b0;
        end else begin
            lock_cnt_r <= lock_cnt_nxt;
            locked_r <= locked_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unmapped addresses read as zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_PLL_CFG: rdata_nxt = pll_cfg_r;
                ADDR_POWER_STATE: rdata_nxt[POWER_ON_BIT] = power_bit_r;
                ADDR_PLL_STATUS: rdata_nxt[LOCK_BIT] = locked_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Internal clocks
    // ------------------------------------------------------------------
    // Master clock near 8 MHz from the core clock; it stops when unpowered.
    always_comb begin
        mdiv_nxt = mdiv_r;
        mclk_nxt = master_logic_clock_o;
        if (pwr_r == PWR_OFF) begin
            mdiv_nxt = 3'h0;
            mclk_nxt = 1'b0;
        end else if (mdiv_r == 3'(MASTER_DIV - 1)) begin
            mdiv_nxt = 3'h0;
            mclk_nxt = ~master_logic_clock_o;
        end else begin
            mdiv_nxt = mdiv_r + 3'h1;
        end
    end

    // Low rates are plain divisions of the oscillator, so they stay in phase.
    clkgen_divider #(.DIV(LOW_DIV_8K)) u_div8k (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .edge_i(xtal_edge),
        .div_o(div8k)
    );

    clkgen_divider #(.DIV(LOW_DIV_1K)) u_div1k (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .edge_i(xtal_edge),
        .div_o(div1k)
    );

    // Register every output so each one leaves a flip-flop.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mdiv_r <= 3'h0;
            master_logic_clock_o <= 1'b0;
            reg_rdata_o <= 8'h00;
            generator_power_o <= 1'b1;
            pll_power_o <= 1'b0;
            pll_ref_o <= 3'h0;
            main_pll_locked_o <= 1'b0;
            out12_en_o <= 1'b0;
            out48_en_o <= 1'b0;
            audio_pll_clock_en_o <= 1'b0;
            low_speed_clock_o <= 1'b0;
            eight_khz_tick_o <= 1'b0;
            one_khz_tick_o <= 1'b0;
            div8k_d_r <= 1'b0;
            div1k_d_r <= 1'b0;
        end else begin
            mdiv_r <= mdiv_nxt;
            master_logic_clock_o <= mclk_nxt;
            reg_rdata_o <= rdata_nxt;
            generator_power_o <= (pwr_nxt != PWR_OFF);
            pll_power_o <= (ref_sel != REF_NONE);
            pll_ref_o <= pll_cfg_r[2:0];
            main_pll_locked_o <= locked_r;
            out12_en_o <= pll_cfg_r[OUT12_EN_BIT] & locked_r;
            out48_en_o <= pll_cfg_r[OUT48_EN_BIT] & locked_r;
            audio_pll_clock_en_o <= locked_r;
            low_speed_clock_o <= xtal_s2_r;
            div8k_d_r <= div8k;
            div1k_d_r <= div1k;
            eight_khz_tick_o <= div8k & ~div8k_d_r;
            one_khz_tick_o <= div1k & ~div1k_d_r;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_irq_sets_power: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        cpu_irq_pending_i |=> power_bit_r)
        else $error("Pending interrupt did not set the power bit.");
    a_write_clears_power: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        reg_wr_i && reg_addr_i == ADDR_POWER_STATE && reg_wdata_i[POWER_ON_BIT]
        && !cpu_irq_pending_i |=> !power_bit_r)
        else $error("Write of one did not clear the power bit.");
    // Eight cycles is well inside the drain time but catches a missing delay.
    a_drain_before_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $fell(power_bit_r) |-> generator_power_o [*8])
        else $error("Power removed without drain delay.");
    a_power_follows_bit: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        power_bit_r |=> ##1 generator_power_o)
        else $error("Generator unpowered while power bit set.");
    a_pll_off_codes: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (pll_cfg_r[1:0] == 2'b00) |=> !pll_power_o)
        else $error("PLL powered for an off code.");
    a_lock_status_read: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == ADDR_PLL_STATUS |=> reg_rdata_o[LOCK_BIT] == $past(locked_r))
        else $error("Lock status read mismatch.");
    a_out_enable_bits: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !pll_cfg_r[OUT48_EN_BIT] |=> !out48_en_o)
        else $error("48 MHz output enabled while disabled in config.");
    a_off_no_lock: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ref_sel == REF_NONE |=> !locked_r)
        else $error("Lock reported with PLL off.");
    a_master_stops: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        pwr_r == PWR_OFF |=> !master_logic_clock_o)
        else $error("Master clock runs while unpowered.");

    c_power_down: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        $fell(generator_power_o));
    c_wake: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        $rose(generator_power_o));
    c_lock: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        $rose(main_pll_locked_o));
    c_tick_1k: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        one_khz_tick_o);

endmodule

/* File: clock_generator_pll_control_tb_top.sv */
/*
 * Self-checking bench for the clock generator control block: register access,
 * select decode, output enables, generator power state and internal clocks.
 * Assumes clkgen_pkg, clkgen_divider and clkgen_ctrl are compiled before it.
 */
module clock_generator_pll_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import clkgen_pkg::*;

    // ------------------------------------------------------------------
    // Signals and limits
    // ------------------------------------------------------------------
    localparam int LOCK_SIM = 4;
    localparam int CEILING = 20000;
    logic clk = 1'b0;
    logic nrst, wr, rd, irq, xtal;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic gen_pwr, pll_pwr, locked, o12, o48, mclk, aud_en, lsc, t8k, t1k;
    logic [2:0] ref_sel;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    logic on;

    // Core clock at 100 MHz.
    always #5 clk = ~clk;

    // The crystal runs much faster than 32.768 kHz to keep the run short; the
    // odd half period lets its edges drift against the core clock.
    always #203 xtal = ~xtal;

    clkgen_ctrl #(.LOCK_CYCLES(LOCK_SIM)) clkgen_ctrl_inst (
        .core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .cpu_irq_pending_i(irq), .crystal_input_i(xtal),
        .generator_power_o(gen_pwr), .pll_power_o(pll_pwr), .pll_ref_o(ref_sel),
        .main_pll_locked_o(locked), .out12_en_o(o12), .out48_en_o(o48),
        .master_logic_clock_o(mclk), .audio_pll_clock_en_o(aud_en),
        .low_speed_clock_o(lsc), .eight_khz_tick_o(t8k), .one_khz_tick_o(t1k)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One-cycle write strobe; the request is held until the taking edge.
    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data is registered, so it is sampled just after the taking edge.
    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wait_lock(input logic exp);
        int k = 0;
        while (locked !== exp && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        check(8'(locked), 8'(exp), "lock status");
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return mclk;
            1: return t8k;
            2: return t1k;
            3: return lsc;
            default: return 1'b0;
        endcase
    endfunction

    // Counts rises of signal u (or cycles when u is negative) after one rise
    // of signal s up to and including the next; a hang is cut by the timeout.
    task automatic gap(input int s, input int u, output int cnt);
        logic ps, pu;
        bit hit;
        ps = pick(s);
        hit = 0;
        cnt = 0;
        while (!hit) begin
            @(posedge clk);
            #1;
            hit = pick(s) && !ps;
            ps = pick(s);
        end
        pu = pick(u);
        hit = 0;
        while (!hit) begin
            @(posedge clk);
            #1;
            if (u < 0 || (pick(u) && !pu))
                cnt++;
            pu = pick(u);
            hit = pick(s) && !ps;
            ps = pick(s);
        end
    endtask

    // ------------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == CEILING) begin
            miscompares++;
            $display("MISMATCH at %0t: run exceeded cycle limit", $time);
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        irq = 1'b0;
        xtal = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        idle(1);
        check(8'(gen_pwr), 8'h01, "power after reset");
        check(8'(pll_pwr), 8'h00, "pll power after reset");
        reg_read(ADDR_PLL_CFG, rv);
        check(rv, 8'hc0, "cfg reset value");
        reg_read(ADDR_POWER_STATE, rv);
        check(8'(rv[4]), 8'h01, "power bit reset");
        reg_read(ADDR_PLL_STATUS, rv);
        check(8'(rv[0]), 8'h00, "lock reset");
        reg_read(16'ha032, rv);
        check(rv, 8'h00, "unmapped read");
        $display("test reset values done");

        // Every select code, each from the off state.
        for (int c = 0; c < 8; c++) begin
            reg_write(ADDR_PLL_CFG, 8'hc0);
            idle(LOCK_SIM + 2);
            wait_lock(1'b0);
            reg_write(ADDR_PLL_CFG, {5'b11000, 3'(c)});
            on = (c != 0 && c != 4);
            idle(1);
            check(8'(pll_pwr), 8'(on), "pll power decode");
            check(8'(ref_sel), 8'(c), "reference select");
            reg_read(ADDR_PLL_CFG, rv);
            check(rv, {5'b11000, 3'(c)}, "cfg readback");
            idle(LOCK_SIM + 2);
            wait_lock(on);
            check(8'(o12), 8'(on), "12 MHz enable");
            check(8'(o48), 8'(on), "48 MHz enable");
            check(8'(aud_en), 8'(on), "audio clock");
            reg_read(ADDR_PLL_STATUS, rv);
            check(8'(rv[0]), 8'(on), "status lock bit");
        end
        $display("test select codes done");

        // Independent output enables, then refused writes.
        for (int v = 0; v < 4; v++) begin
            reg_write(ADDR_PLL_CFG, {2'(v), 6'b000111});
            idle(2);
            check(8'(o12), 8'(v & 1), "12 MHz enable bit");
            check(8'(o48), 8'(v >> 1), "48 MHz enable bit");
        end
        reg_write(ADDR_PLL_STATUS, 8'h00);
        reg_read(ADDR_PLL_STATUS, rv);
        check(8'(rv[0]), 8'h01, "status write ignored");
        reg_write(16'ha033, 8'hff);
        reg_read(ADDR_PLL_CFG, rv);
        check(rv, 8'hc7, "unmapped write ignored");
        $display("test output enables done");

        // Internal clock rates.
        gap(0, -1, n);
        check(8'(n), 8'h0c, "master clock period");
        gap(1, 3, n);
        check(8'(n), 8'h04, "8 kHz per crystal");
        gap(2, 3, n);
        check(8'(n), 8'h20, "1 kHz per crystal");
        gap(3, -1, n);
        check(8'(n >= 39 && n <= 42), 8'h01, "low speed follows crystal");
        $display("test internal clocks done");

        // Power state bit: zero write, interrupt priority, clear and wake.
        reg_write(ADDR_POWER_STATE, 8'h00);
        reg_read(ADDR_POWER_STATE, rv);
        check(8'(rv[4]), 8'h01, "zero write keeps bit");
        @(posedge clk);
        irq <= 1'b1;
        reg_write(ADDR_POWER_STATE, 8'h10);
        reg_read(ADDR_POWER_STATE, rv);
        check(8'(rv[4]), 8'h01, "interrupt holds bit");
        @(posedge clk);
        irq <= 1'b0;
        reg_write(ADDR_POWER_STATE, 8'h10);
        reg_read(ADDR_POWER_STATE, rv);
        check(8'(rv[4]), 8'h00, "write one clears");
        check(8'(gen_pwr), 8'h01, "power held during drain");
        n = 0;
        while (gen_pwr !== 1'b0 && n < 60) begin
            idle(1);
            n++;
        end
        check(8'(gen_pwr), 8'h00, "power removed");
        // Power falls one edge after the drain count ends; the wait began two edges late.
        check(8'(n), 8'(POWER_OFF_DELAY_CYC - 1), "drain length");
        idle(2);
        check(8'(mclk), 8'h00, "master clock stopped");
        idle(7);
        check(8'(mclk), 8'h00, "master clock stays stopped");
        @(posedge clk);
        irq <= 1'b1;
        idle(4);
        check(8'(gen_pwr), 8'h01, "interrupt restores power");
        reg_read(ADDR_POWER_STATE, rv);
        check(8'(rv[4]), 8'h01, "interrupt sets bit");
        @(posedge clk);
        irq <= 1'b0;
        #1;
        gap(0, -1, n);
        check(8'(n), 8'h0c, "master clock resumes");
        $display("test power state done");
        report_and_stop();
    end
endmodule
